// ==== common/lhp_pkg.sv ====
// Purpose: Constants and types for the local host port page window.
// Assumes: One 20 MHz clock; host pins already synchronous or synchronised.
// Notes: Page register offsets are host byte addresses within 64 bytes.
package lhp_pkg;
  localparam int CLOCK_MHZ = 20;
  localparam int READY_PULSE_NS = 20;
  localparam int READY_CYCLES_RAW = (READY_PULSE_NS * CLOCK_MHZ) / 1000;
  localparam int READY_CYCLES = (READY_CYCLES_RAW < 1) ? 1 : READY_CYCLES_RAW;
  // Page register offsets, one page every 16 bytes
  localparam logic [3:0] OFS_RANGE_LOW = 4'h0;
  localparam logic [3:0] OFS_RANGE_HIGH = 4'h2;
  localparam logic [3:0] OFS_OFFSET_LOW = 4'h4;
  localparam logic [3:0] OFS_OFFSET_HIGH = 4'h6;
  localparam logic [3:0] OFS_WIDTH_CONFIG = 4'h8;
  // Field positions in the 32-bit range and offset values
  localparam int RANGE_LSB = 8;
  localparam int RANGE_MSB = 21;
  localparam int OFFSET_LSB = 8;
  localparam logic [15:0] RESET_VALUE = 16'h0000;
  // Host byte enables (active low) with address bit 0
  localparam logic [1:0] BE_LOW_BYTE = 2'b10;
  localparam logic [1:0] BE_HIGH_BYTE = 2'b01;
  localparam logic [1:0] BE_WORD = 2'b00;
  typedef enum logic [2:0] {
    LHP_IDLE = 3'b000,
    LHP_BUSY = 3'b001,
    LHP_SYS = 3'b010,
    LHP_READY = 3'b011,
    LHP_DONE = 3'b100
  } lhp_state_t;
endpackage

// ==== rtl/lhp_local_host_port.sv ====
// Purpose: Host-facing slave port mapping four pages onto a 32-bit bus.
// Assumes: Host strobes are asynchronous; the system bus holds ack one cycle.
// Notes: Ready pin and data pin are split into value and low-active enable.
`timescale 1ns/1ps
`default_nettype none
module lhp_local_host_port #(
  parameter int PAGES = 4
) (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic NRST,
  // Static configuration pins
  input wire logic BUS_SYSTEM_SELECT,
  input wire logic STROBE_STYLE_SELECT,
  input wire logic READY_POLARITY_SELECT,
  // Host bus
  input wire logic [20:0] HOST_ADDR,
  input wire logic [15:0] HOST_DATA_IN,
  output logic [15:0] HOST_DATA_OUT,
  output logic HOST_DATA_OE_N,
  input wire logic HOST_WRITE_STROBE_N,
  input wire logic HOST_READ_STROBE_N,
  input wire logic [1:0] HOST_BYTE_EN_N,
  input wire logic [1:0] PAGE_SELECT,
  input wire logic INTERNAL_SPACE_CS_N,
  input wire logic PAGE_REGS_CS_N,
  output logic HOST_READY_OUT,
  output logic HOST_READY_OE_N,
  // System bus master
  output logic SYS_REQ,
  output logic SYS_WRITE,
  output logic [31:0] SYS_ADDR,
  output logic [31:0] SYS_WDATA,
  output logic [3:0] SYS_BE,
  input wire logic SYS_ACK,
  input wire logic [31:0] SYS_RDATA
);
  // Register map decodes exactly two page bits
  if (PAGES != 4) begin : g_pages_check
    $error("lhp_local_host_port serves exactly four pages");
  end

  localparam int RANGE_W = lhp_pkg::RANGE_MSB - lhp_pkg::RANGE_LSB + 1;
  localparam int OFFS_W = 32 - lhp_pkg::OFFSET_LSB;
  lhp_pkg::lhp_state_t state;
  logic [1:0] sync_cs_m, sync_cs_r, sync_wr, sync_rd;
  logic [RANGE_W-1:0] page_range [PAGES];
  logic [OFFS_W-1:0] page_offset [PAGES];
  logic [PAGES-1:0] page_wide;
  logic [15:0] held_high, held_low;
  logic [7:0] pulse_count;
  logic acc_write, acc_regs, cs_on, strobe_on, start, legal, is_word;
  logic [1:0] pg;
  logic [31:0] next_addr;

  // Bus address of one host access through one page
  function automatic logic [31:0] map_addr(input logic [RANGE_W-1:0] rng,
      input logic [OFFS_W-1:0] ofs, input logic [20:0] ha);
    logic [31:0] mask;
    mask = 32'h0000_00FF;
    for (int k = 0; k < RANGE_W; k++) begin
      if (rng[k]) begin
        mask = (32'h0000_0001 << (k + lhp_pkg::RANGE_LSB)) - 32'h0000_0001;
      end
    end
    map_addr = ({ofs, 8'h00} & ~mask) | ({11'h000, ha} & mask);
  endfunction

  // Two-stage synchronisers on chip selects and strobes
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      sync_cs_m <= 2'b11;
      sync_cs_r <= 2'b11;
      sync_wr <= 2'b11;
      sync_rd <= 2'b11;
    end else begin
      sync_cs_m <= {sync_cs_m[0], INTERNAL_SPACE_CS_N};
      sync_cs_r <= {sync_cs_r[0], PAGE_REGS_CS_N};
      sync_wr <= {sync_wr[0], HOST_WRITE_STROBE_N};
      sync_rd <= {sync_rd[0], HOST_READ_STROBE_N};
    end
  end

  always_comb begin
    cs_on = !sync_cs_m[1] || !sync_cs_r[1];
    // Common line style ignores the read strobe
    if (STROBE_STYLE_SELECT) begin
      strobe_on = cs_on;
      acc_write = !sync_wr[1];
    end else begin
      strobe_on = cs_on && (!sync_wr[1] || !sync_rd[1]);
      acc_write = !sync_wr[1];
    end
    start = !BUS_SYSTEM_SELECT && strobe_on;
    acc_regs = !sync_cs_r[1];
    pg = PAGE_SELECT;
    is_word = (HOST_BYTE_EN_N == lhp_pkg::BE_WORD) && !HOST_ADDR[0];
    legal = is_word
      || (HOST_BYTE_EN_N == lhp_pkg::BE_LOW_BYTE && !HOST_ADDR[0])
      || (HOST_BYTE_EN_N == lhp_pkg::BE_HIGH_BYTE && HOST_ADDR[0]);
    next_addr = map_addr(page_range[pg], page_offset[pg], HOST_ADDR);
  end

  // Page registers, written from the host by word writes only
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      for (int p = 0; p < PAGES; p++) begin
        page_range[p] <= RANGE_W'(lhp_pkg::RESET_VALUE);
        page_offset[p] <= OFFS_W'(lhp_pkg::RESET_VALUE);
      end
      page_wide <= '0;
    end else if (state == lhp_pkg::LHP_BUSY && acc_regs && acc_write
        && is_word) begin
      case ({HOST_ADDR[3:1], 1'b0})
        lhp_pkg::OFS_RANGE_LOW: page_range[HOST_ADDR[5:4]][7:0] <=
          HOST_DATA_IN[15:8];
        lhp_pkg::OFS_RANGE_HIGH: page_range[HOST_ADDR[5:4]][13:8] <=
          HOST_DATA_IN[5:0];
        lhp_pkg::OFS_OFFSET_LOW: page_offset[HOST_ADDR[5:4]][7:0] <=
          HOST_DATA_IN[15:8];
        lhp_pkg::OFS_OFFSET_HIGH: page_offset[HOST_ADDR[5:4]][23:8] <=
          HOST_DATA_IN;
        lhp_pkg::OFS_WIDTH_CONFIG: page_wide[HOST_ADDR[5:4]] <=
          HOST_DATA_IN[0];
        default: ;
      endcase
    end
  end

  // Access sequencer
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      state <= lhp_pkg::LHP_IDLE;
      pulse_count <= '0;
      SYS_REQ <= 1'b0;
      SYS_WRITE <= 1'b0;
      SYS_ADDR <= '0;
      SYS_WDATA <= '0;
      SYS_BE <= '0;
      held_high <= '0;
      held_low <= '0;
      HOST_DATA_OUT <= '0;
    end else begin
      case (state)
        lhp_pkg::LHP_IDLE: begin
          if (start) begin
            state <= lhp_pkg::LHP_BUSY;
          end
        end
        lhp_pkg::LHP_BUSY: begin
          state <= lhp_pkg::LHP_READY;
          pulse_count <= 8'(lhp_pkg::READY_CYCLES);
          if (acc_regs) begin
            case ({HOST_ADDR[3:1], 1'b0})
              lhp_pkg::OFS_RANGE_LOW:
                HOST_DATA_OUT <= {page_range[HOST_ADDR[5:4]][7:0], 8'h00};
              lhp_pkg::OFS_RANGE_HIGH:
                HOST_DATA_OUT <= {10'h000, page_range[HOST_ADDR[5:4]][13:8]};
              lhp_pkg::OFS_OFFSET_LOW:
                HOST_DATA_OUT <= {page_offset[HOST_ADDR[5:4]][7:0], 8'h00};
              lhp_pkg::OFS_OFFSET_HIGH:
                HOST_DATA_OUT <= page_offset[HOST_ADDR[5:4]][23:8];
              lhp_pkg::OFS_WIDTH_CONFIG:
                HOST_DATA_OUT <= {15'h0000, page_wide[HOST_ADDR[5:4]]};
              default: HOST_DATA_OUT <= '0;
            endcase
          end else if (!legal) begin
            HOST_DATA_OUT <= '0;
          end else if (page_wide[pg] && is_word && HOST_ADDR[1]) begin
            if (acc_write) begin
              state <= lhp_pkg::LHP_SYS;
              SYS_REQ <= 1'b1;
              SYS_WRITE <= 1'b1;
              SYS_ADDR <= {next_addr[31:2], 2'b00};
              SYS_WDATA <= {HOST_DATA_IN, held_low};
              SYS_BE <= 4'hF;
            end else begin
              HOST_DATA_OUT <= held_high;
            end
          end else if (page_wide[pg] && is_word && acc_write) begin
            held_low <= HOST_DATA_IN;
          end else begin
            state <= lhp_pkg::LHP_SYS;
            SYS_REQ <= 1'b1;
            SYS_WRITE <= acc_write;
            SYS_WDATA <= {HOST_DATA_IN, HOST_DATA_IN};
            if (page_wide[pg] && is_word) begin
              SYS_ADDR <= {next_addr[31:2], 2'b00};
              SYS_BE <= 4'hF;
            end else begin
              SYS_ADDR <= next_addr;
              SYS_BE <= next_addr[1] ? {~HOST_BYTE_EN_N, 2'b00}
                                     : {2'b00, ~HOST_BYTE_EN_N};
            end
          end
        end
        lhp_pkg::LHP_SYS: begin
          if (SYS_ACK) begin
            SYS_REQ <= 1'b0;
            state <= lhp_pkg::LHP_READY;
            pulse_count <= 8'(lhp_pkg::READY_CYCLES);
            // A wide write must not clobber the held high half
            if (SYS_BE == 4'hF && !SYS_WRITE) begin
              held_high <= SYS_RDATA[31:16];
              HOST_DATA_OUT <= SYS_RDATA[15:0];
            end else begin
              HOST_DATA_OUT <= SYS_ADDR[1] ? SYS_RDATA[31:16]
                                           : SYS_RDATA[15:0];
            end
          end
        end
        lhp_pkg::LHP_READY: begin
          pulse_count <= pulse_count - 8'h01;
          if (pulse_count == 8'h01) begin
            state <= lhp_pkg::LHP_DONE;
          end
        end
        lhp_pkg::LHP_DONE: begin
          if (!strobe_on) begin
            state <= lhp_pkg::LHP_IDLE;
          end
        end
        default: state <= lhp_pkg::LHP_IDLE;
      endcase
    end
  end

  // Ready pin: inactive while busy, active one pulse, else released
  always_comb begin
    HOST_READY_OE_N = !(state == lhp_pkg::LHP_BUSY
      || state == lhp_pkg::LHP_SYS || state == lhp_pkg::LHP_READY);
    HOST_READY_OUT = (state == lhp_pkg::LHP_READY) ? READY_POLARITY_SELECT
                                                   : !READY_POLARITY_SELECT;
    HOST_DATA_OE_N = !(!acc_write && strobe_on
      && (state == lhp_pkg::LHP_READY || state == lhp_pkg::LHP_DONE));
  end
endmodule // lhp_local_host_port
`default_nettype wire

// ==== verification/lhp_port_assertions.sv ====
// Purpose: Timing checks on the host port pins and system bus.
// Assumes: Ready active means driven and at the selected polarity.
// Notes: Bound to the port module below.
`timescale 1ns/1ps
`default_nettype none
module lhp_port_assertions (
  input wire logic CLOCK,
  input wire logic NRST,
  input wire logic BUS_SYSTEM_SELECT,
  input wire logic READY_POLARITY_SELECT,
  input wire logic PAGE_REGS_CS_N,
  input wire logic HOST_DATA_OE_N,
  input wire logic HOST_READY_OUT,
  input wire logic HOST_READY_OE_N,
  input wire logic SYS_REQ,
  input wire logic [31:0] SYS_ADDR,
  input wire logic [3:0] SYS_BE,
  input wire logic SYS_ACK
);
  logic rdy_on;
  assign rdy_on = !HOST_READY_OE_N && HOST_READY_OUT == READY_POLARITY_SELECT;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!NRST);
  ready_pulse_a: assert property (rdy_on |=> HOST_READY_OE_N)
    else $error("ready held past one cycle");
  ready_inactive_a: assert property ($fell(HOST_READY_OE_N) |->
    HOST_READY_OUT != READY_POLARITY_SELECT)
    else $error("ready not inactive when first driven");
  ack_ready_a: assert property (SYS_REQ && SYS_ACK |=> rdy_on)
    else $error("no ready after bus ack");
  req_drop_a: assert property (SYS_REQ && SYS_ACK |=> !SYS_REQ)
    else $error("bus request kept after ack");
  req_hold_a: assert property (SYS_REQ && !SYS_ACK |=> SYS_REQ &&
    $stable(SYS_ADDR) && $stable(SYS_BE))
    else $error("bus request changed before ack");
  reg_local_a: assert property (!PAGE_REGS_CS_N |-> !SYS_REQ)
    else $error("bus access during register select");
  port_off_a: assert property (BUS_SYSTEM_SELECT [*2] ##0
    HOST_READY_OE_N |=> HOST_READY_OE_N)
    else $error("access started while port disabled");
  data_ready_a: assert property ($fell(HOST_DATA_OE_N) |-> rdy_on)
    else $error("read data driven without ready");
endmodule // lhp_port_assertions
bind lhp_local_host_port lhp_port_assertions u_chk (.CLOCK, .NRST,
  .BUS_SYSTEM_SELECT, .READY_POLARITY_SELECT, .PAGE_REGS_CS_N,
  .HOST_DATA_OE_N, .HOST_READY_OUT, .HOST_READY_OE_N, .SYS_REQ,
  .SYS_ADDR, .SYS_BE, .SYS_ACK);
`default_nettype wire

// ==== verification/lhp_sys_model.sv ====
// Purpose: System bus responder behind the local host port.
// Assumes: One ack pulse per request; read data follows the address.
// Notes: Data lines toggle while no ack is given.
`timescale 1ns/1ps
`default_nettype none
module lhp_sys_model (
  // Clock, reset and slow-response select
  input wire logic clock,
  input wire logic nrst,
  input wire logic slow,
  // Bus from the port
  input wire logic req,
  input wire logic write,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire logic [3:0] be,
  output logic ack,
  output logic [31:0] rdata,
  // Last transfer seen and transfer count
  output logic [31:0] last_addr,
  output logic [31:0] last_wdata,
  output logic [3:0] last_be,
  output logic last_write,
  output int reqs
);
  logic [2:0] waits;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ack <= 1'b0;
      waits <= 3'h0;
      reqs <= 0;
      rdata <= 32'h0000_0000;
      last_addr <= 32'h0000_0000;
      last_wdata <= 32'h0000_0000;
      last_be <= 4'h0;
      last_write <= 1'b0;
    end else begin
      ack <= 1'b0;
      rdata <= ~rdata;
      if (req && !ack && waits >= (slow ? 3'h4 : 3'h0)) begin
        ack <= 1'b1;
        waits <= 3'h0;
        reqs <= reqs + 1;
        rdata <= {~addr[15:0], addr[15:0]};
        last_addr <= addr;
        last_wdata <= wdata;
        last_be <= be;
        last_write <= write;
      end else if (req && !ack) begin
        waits <= waits + 3'h1;
      end
    end
  end
endmodule // lhp_sys_model
`default_nettype wire

// ==== verification/tb_top.sv ====
// Purpose: Directed host accesses through the page window.
// Assumes: Host waits for ready and releases strobes after it.
// Notes: Page 1 maps a 128 kB window at 1010_0000.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic CLOCK = 1'b0, NRST = 1'b0, BUS_SYSTEM_SELECT = 1'b1;
  logic STROBE_STYLE_SELECT = 1'b0, READY_POLARITY_SELECT = 1'b0;
  logic HOST_WRITE_STROBE_N = 1'b1, HOST_READ_STROBE_N = 1'b1;
  logic INTERNAL_SPACE_CS_N = 1'b1, PAGE_REGS_CS_N = 1'b1, slow = 1'b0;
  logic [20:0] HOST_ADDR = 21'h00_0000;
  logic [15:0] HOST_DATA_IN = 16'h0000, HOST_DATA_OUT, q;
  logic [1:0] HOST_BYTE_EN_N = 2'b11, PAGE_SELECT = 2'b00;
  logic HOST_DATA_OE_N, HOST_READY_OUT, HOST_READY_OE_N;
  logic SYS_REQ, SYS_WRITE, SYS_ACK, last_write;
  logic [31:0] SYS_ADDR, SYS_WDATA, SYS_RDATA, last_addr, last_wdata;
  logic [3:0] SYS_BE, last_be;
  int reqs, n0, fails = 0, checked = 0, cycles = 0;
  always #25 CLOCK = ~CLOCK;
  lhp_local_host_port u_dut (.CLOCK, .NRST, .BUS_SYSTEM_SELECT,
    .STROBE_STYLE_SELECT, .READY_POLARITY_SELECT, .HOST_ADDR, .HOST_DATA_IN,
    .HOST_DATA_OUT, .HOST_DATA_OE_N, .HOST_WRITE_STROBE_N,
    .HOST_READ_STROBE_N, .HOST_BYTE_EN_N, .PAGE_SELECT, .INTERNAL_SPACE_CS_N,
    .PAGE_REGS_CS_N, .HOST_READY_OUT, .HOST_READY_OE_N, .SYS_REQ, .SYS_WRITE,
    .SYS_ADDR, .SYS_WDATA, .SYS_BE, .SYS_ACK, .SYS_RDATA);
  lhp_sys_model u_sys (.clock(CLOCK), .nrst(NRST), .slow(slow), .req(SYS_REQ),
    .write(SYS_WRITE), .addr(SYS_ADDR), .wdata(SYS_WDATA), .be(SYS_BE),
    .ack(SYS_ACK), .rdata(SYS_RDATA), .last_addr(last_addr),
    .last_wdata(last_wdata), .last_be(last_be), .last_write(last_write),
    .reqs(reqs));
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic acc(input logic rg, input logic wr, input logic [20:0] a,
      input logic [15:0] d, input logic [1:0] be, output logic [15:0] r);
    int n;
    n = 0;
    @(posedge CLOCK) #2;
    HOST_ADDR = a;
    HOST_BYTE_EN_N = be;
    HOST_DATA_IN = wr ? d : ~d;
    PAGE_REGS_CS_N = !rg;
    INTERNAL_SPACE_CS_N = rg;
    HOST_WRITE_STROBE_N = !wr;
    HOST_READ_STROBE_N = wr | STROBE_STYLE_SELECT;
    do begin
      @(posedge CLOCK);
      #1;
      n++;
    end while (!(HOST_READY_OE_N === 1'b0 &&
      HOST_READY_OUT === READY_POLARITY_SELECT) && n < 40);
    r = HOST_DATA_OUT;
    cmp("ready_seen", 32'h0000_0001, 32'(n < 40));
    // Hold the request through the edge that samples ready
    @(posedge CLOCK) #2;
    {PAGE_REGS_CS_N, INTERNAL_SPACE_CS_N} = 2'b11;
    {HOST_WRITE_STROBE_N, HOST_READ_STROBE_N} = 2'b11;
    HOST_DATA_IN = ~HOST_DATA_IN;
    repeat (4) @(posedge CLOCK);
    #2;
  endtask
  task automatic wr_reg(input logic [20:0] a, input logic [15:0] d);
    acc(1'b1, 1'b1, a, d, lhp_pkg::BE_WORD, q);
  endtask
  task automatic rd(input logic rg, input logic [20:0] a, input logic [1:0] be);
    acc(rg, 1'b0, a, 16'h0000, be, q);
  endtask
  task automatic final_report;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge CLOCK) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      $display("ERROR timeout expected end seen hang");
      final_report();
    end
  end
  initial begin
    repeat (10) @(posedge CLOCK);
    #2 NRST = 1'b1;
    repeat (3) @(posedge CLOCK);
    // Strobe while the port is disabled: no answer, no bus access
    #2 INTERNAL_SPACE_CS_N = 1'b0;
    HOST_READ_STROBE_N = 1'b0;
    HOST_BYTE_EN_N = lhp_pkg::BE_WORD;
    repeat (8) @(posedge CLOCK);
    #1 cmp("port_off_ready", 32'h0000_0001, 32'(HOST_READY_OE_N));
    cmp("port_off_reqs", 32'h0000_0000, reqs);
    #1 {INTERNAL_SPACE_CS_N, HOST_READ_STROBE_N} = 2'b11;
    $display("test port disable done");
    repeat (3) @(posedge CLOCK);
    #2 BUS_SYSTEM_SELECT = 1'b0;
    PAGE_SELECT = 2'b11;
    rd(1'b1, 21'h00_0026, lhp_pkg::BE_WORD);
    cmp("offset_high_reset", 32'h0000_0000, q);
    wr_reg(21'h00_0012, 16'hFFFF);
    rd(1'b1, 21'h00_0012, lhp_pkg::BE_WORD);
    cmp("range_high_mask", 32'h0000_003F, q);
    wr_reg(21'h00_0050, 16'hFFFF);
    rd(1'b1, 21'h00_0010, lhp_pkg::BE_WORD);
    cmp("range_low_mirror", 32'h0000_FF00, q);
    wr_reg(21'h00_0012, 16'h0002);
    wr_reg(21'h00_0014, 16'hFFFF);
    wr_reg(21'h00_0016, 16'h1010);
    rd(1'b1, 21'h00_0014, lhp_pkg::BE_WORD);
    cmp("offset_low_mask", 32'h0000_FF00, q);
    $display("test registers done");
    PAGE_SELECT = 2'b01;
    slow = 1'b1;
    rd(1'b0, 21'h02_0004, lhp_pkg::BE_WORD);
    cmp("page1_addr", 32'h1010_0004, last_addr);
    cmp("page1_data", 32'h0000_0004, q);
    cmp("page1_be", 32'h0000_0003, last_be);
    PAGE_SELECT = 2'b00;
    slow = 1'b0;
    rd(1'b0, 21'h01_2346, lhp_pkg::BE_WORD);
    cmp("page0_addr", 32'h0000_0046, last_addr);
    cmp("page0_data", 32'h0000_FFB9, q);
    $display("test mapping done");
    {STROBE_STYLE_SELECT, READY_POLARITY_SELECT, PAGE_SELECT} = 4'b1101;
    acc(1'b0, 1'b1, 21'h00_0003, 16'hAB00, lhp_pkg::BE_HIGH_BYTE, q);
    cmp("byte_write", 32'h1, 32'(last_write));
    cmp("byte_be", 32'h0000_0008, last_be);
    cmp("byte_data", 32'hAB00_AB00, last_wdata);
    rd(1'b0, 21'h00_0008, lhp_pkg::BE_WORD);
    cmp("combined_read", 32'h0000_0008, q);
    {STROBE_STYLE_SELECT, READY_POLARITY_SELECT} = 2'b00;
    $display("test strobe style done");
    wr_reg(21'h00_0018, 16'h0001);
    n0 = reqs;
    rd(1'b0, 21'h00_0010, lhp_pkg::BE_WORD);
    cmp("wide_low_be", 32'h0000_000F, last_be);
    rd(1'b0, 21'h00_0012, lhp_pkg::BE_WORD);
    cmp("wide_high_data", 32'h0000_FFEF, q);
    acc(1'b0, 1'b1, 21'h00_0020, 16'h1111, lhp_pkg::BE_WORD, q);
    cmp("wide_low_held", n0 + 1, reqs);
    acc(1'b0, 1'b1, 21'h00_0022, 16'h2222, lhp_pkg::BE_WORD, q);
    cmp("wide_write", 32'h2222_1111, last_wdata);
    cmp("wide_addr", 32'h1010_0020, last_addr);
    $display("test wide page done");
    final_report();
  end
endmodule // tb_top
`default_nettype wire
